// File: core/trgsd_pkg.sv
// Overview of operation
// - direction high shifts stage contents from output one toward output 154.
// - direction low shifts stage contents from output 154 toward output one.
// - direction high makes forward pin input, reverse pin output; low swaps them.
// - the active input pin level is captured into the first stage on rising shift clock.
// - each later rising edge passes every active stage onward while the first stage captures.
// - last stage drives the output data pin, updated on the falling shift clock edge.
// - mode high gives 150 outputs, stages 76 to 79 bypassed and held off.
// - mode low gives all 154 outputs in one continuous chain.
// - active outputs form three interleaved groups; in 150 mode 80 restarts group one.
// - a high group blank forces its outputs off; low lets them follow their stage.
// - group blanks act on outputs without reference to the shift clock.
// - group membership depends only on output count mode, not direction.
package trgsd_pkg;
  localparam int          NUM_STAGES   = 154;
  localparam int          BYP_FIRST    = 75;   // zero-based index of output 76
  localparam int          BYP_LAST     = 78;   // zero-based index of output 79
  localparam int          RESUME_IDX   = 79;   // zero-based index of output 80
  localparam int          NUM_GROUPS   = 3;
  localparam int          SYNC_W       = 8;
  localparam int          ADDR_W       = 8;
  localparam logic [7:0]  REG_CTRL     = 8'h00;
  localparam logic [7:0]  REG_STATUS   = 8'h04;
  localparam int          CTRL_FLUSH   = 0;
  localparam int          ST_DIR       = 0;
  localparam int          ST_MODE      = 1;
  localparam int          ST_BLANK     = 2;
  localparam int          ST_CASCADE   = 5;
  localparam int          ST_SHCLK     = 6;
  localparam logic [1:0]  RESP_OKAY    = 2'h0;
  localparam logic [1:0]  RESP_SLVERR  = 2'h2;
  localparam logic [31:0] CTRL_RESET   = 32'h0000_0000;
endpackage

// File: core/trgsd_sync.sv
`timescale 1ns/1ps
`default_nettype none
module trgsd_sync
  import trgsd_pkg::*;
#(
  parameter int W = SYNC_W
)(
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] level_q
);
  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  logic [W-1:0] s3_q;
  logic [W-1:0] level_d;

  genvar i;
  generate
    for (i = 0; i < W; i++)
    begin : g_bit
      // a change counts only once the second and third stages agree
      assign level_d[i] = (s2_q[i] == s3_q[i]) ? s3_q[i] : level_q[i];
    end
  endgenerate

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s1_q    <= '0;
      s2_q    <= '0;
      s3_q    <= '0;
      level_q <= '0;
    end
    else
    begin
      s1_q    <= async_in;
      s2_q    <= s1_q;
      s3_q    <= s2_q;
      level_q <= level_d;
    end
  end
endmodule
`default_nettype wire

// File: core/trgsd_axil.sv
`timescale 1ns/1ps
`default_nettype none
module trgsd_axil
  import trgsd_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              rst_n,
  input  wire logic [ADDR_W-1:0] awaddr,
  input  wire logic              awvalid,
  output logic                   awready_q,
  input  wire logic [31:0]       wdata,
  input  wire logic [3:0]        wstrb,
  input  wire logic              wvalid,
  output logic                   wready_q,
  output logic [1:0]             bresp_q,
  output logic                   bvalid_q,
  input  wire logic              bready,
  input  wire logic [ADDR_W-1:0] araddr,
  input  wire logic              arvalid,
  output logic                   arready_q,
  output logic [31:0]            rdata_q,
  output logic [1:0]             rresp_q,
  output logic                   rvalid_q,
  input  wire logic              rready,
  input  wire logic [31:0]       status,
  output logic [31:0]            ctrl_q
);
  logic [ADDR_W-1:0] waddr_q;
  logic [31:0]       wdat_q;
  logic [3:0]        wstb_q;
  wire               aw_hs     = awvalid & awready_q;
  wire               w_hs      = wvalid & wready_q;
  wire               do_write  = ~awready_q & ~wready_q & ~bvalid_q;
  wire               wr_ctrl   = do_write & (waddr_q == REG_CTRL);
  wire               wr_status = do_write & (waddr_q == REG_STATUS);
  wire               ar_hs     = arvalid & arready_q;
  wire               rd_ctrl   = araddr == REG_CTRL;
  wire               rd_status = araddr == REG_STATUS;
  wire               rd_hit    = rd_ctrl | rd_status;
  wire [31:0]        rd_word   = rd_ctrl ? ctrl_q : (rd_status ? status : 32'h0000_0000);
  wire [31:0]        ctrl_d    = wr_ctrl ? ((ctrl_q & ~{{8{wstb_q[3]}}, {8{wstb_q[2]}}, {8{wstb_q[1]}}, {8{wstb_q[0]}}})
                                 | (wdat_q & {{8{wstb_q[3]}}, {8{wstb_q[2]}}, {8{wstb_q[1]}}, {8{wstb_q[0]}}}))
                                 : ctrl_q;

  // address and data are taken in either order; the answer follows both
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      awready_q <= 1'b1;
      wready_q  <= 1'b1;
      bvalid_q  <= 1'b0;
      bresp_q   <= RESP_OKAY;
      waddr_q   <= '0;
      wdat_q    <= '0;
      wstb_q    <= '0;
      ctrl_q    <= CTRL_RESET;
    end
    else
    begin
      if (aw_hs)
      begin
        awready_q <= 1'b0;
        waddr_q   <= awaddr;
      end
      if (w_hs)
      begin
        wready_q <= 1'b0;
        wdat_q   <= wdata;
        wstb_q   <= wstrb;
      end
      if (do_write)
      begin
        bvalid_q <= 1'b1;
        // status is read-only, so a write there is answered as an error
        bresp_q  <= (wr_ctrl | wr_status) & ~wr_status ? RESP_OKAY : RESP_SLVERR;
      end
      if (bvalid_q & bready)
      begin
        bvalid_q  <= 1'b0;
        awready_q <= 1'b1;
        wready_q  <= 1'b1;
      end
      ctrl_q <= ctrl_d;
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      arready_q <= 1'b1;
      rvalid_q  <= 1'b0;
      rdata_q   <= '0;
      rresp_q   <= RESP_OKAY;
    end
    else
    begin
      if (ar_hs)
      begin
        arready_q <= 1'b0;
        rvalid_q  <= 1'b1;
        rdata_q   <= rd_word;
        rresp_q   <= rd_hit ? RESP_OKAY : RESP_SLVERR;
      end
      if (rvalid_q & rready)
      begin
        rvalid_q  <= 1'b0;
        arready_q <= 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// File: core/trgsd_top.sv
`timescale 1ns/1ps
`default_nettype none
module trgsd_top
  import trgsd_pkg::*;
(
  input  wire logic                  REF_CLK,
  input  wire logic                  ARST_N,
  input  wire logic                  VERTICAL_SHIFT_CLOCK,
  input  wire logic                  SHIFT_DIRECTION,
  input  wire logic                  MODE_150,
  input  wire logic                  GROUP_ONE_BLANK,
  input  wire logic                  GROUP_TWO_BLANK,
  input  wire logic                  GROUP_THREE_BLANK,
  input  wire logic                  FORWARD_DATA_PORT_I,
  output logic                       FORWARD_DATA_PORT_O,
  output logic                       FORWARD_DATA_PORT_OE,
  input  wire logic                  REVERSE_DATA_PORT_I,
  output logic                       REVERSE_DATA_PORT_O,
  output logic                       REVERSE_DATA_PORT_OE,
  output logic [NUM_STAGES-1:0]      ROW_GATE_OUTPUTS,
  input  wire logic [ADDR_W-1:0]     S_AXI_AWADDR,
  input  wire logic                  S_AXI_AWVALID,
  output logic                       S_AXI_AWREADY,
  input  wire logic [31:0]           S_AXI_WDATA,
  input  wire logic [3:0]            S_AXI_WSTRB,
  input  wire logic                  S_AXI_WVALID,
  output logic                       S_AXI_WREADY,
  output logic [1:0]                 S_AXI_BRESP,
  output logic                       S_AXI_BVALID,
  input  wire logic                  S_AXI_BREADY,
  input  wire logic [ADDR_W-1:0]     S_AXI_ARADDR,
  input  wire logic                  S_AXI_ARVALID,
  output logic                       S_AXI_ARREADY,
  output logic [31:0]                S_AXI_RDATA,
  output logic [1:0]                 S_AXI_RRESP,
  output logic                       S_AXI_RVALID,
  input  wire logic                  S_AXI_RREADY
);
  logic                  rst_meta_q;
  logic                  rst_n_q;
  logic [SYNC_W-1:0]     pin_lvl;
  logic                  shclk_prev_q;
  logic [NUM_STAGES-1:0] chain_q;
  logic [NUM_STAGES-1:0] chain_d;
  logic [NUM_STAGES-1:0] row_d;
  logic                  cascade_q;
  logic [31:0]           ctrl;

  always_ff @(posedge REF_CLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      rst_meta_q <= 1'b0;
      rst_n_q    <= 1'b0;
    end
    else
    begin
      rst_meta_q <= 1'b1;
      rst_n_q    <= rst_meta_q;
    end
  end

  // every pin passes the same depth, so data keeps its setup against the clock edge
  trgsd_sync #(.W(SYNC_W)) u_sync (
    .clk      (REF_CLK),
    .rst_n    (rst_n_q),
    .async_in ({REVERSE_DATA_PORT_I, FORWARD_DATA_PORT_I, GROUP_THREE_BLANK, GROUP_TWO_BLANK,
                GROUP_ONE_BLANK, MODE_150, SHIFT_DIRECTION, VERTICAL_SHIFT_CLOCK}),
    .level_q  (pin_lvl)
  );

  wire       shclk    = pin_lvl[0];
  wire       dir_up   = pin_lvl[1];
  wire       mode150  = pin_lvl[2];
  wire [2:0] blank    = pin_lvl[5:3];
  wire       fwd_in   = pin_lvl[6];
  wire       rev_in   = pin_lvl[7];
  wire       sh_rise  = shclk & ~shclk_prev_q;
  wire       sh_fall  = ~shclk & shclk_prev_q;
  wire       flush    = ctrl[CTRL_FLUSH];
  wire       in_bit   = dir_up ? fwd_in : rev_in;
  // in 150 mode the bypassed stages stay at zero, so the last stage is unchanged
  wire       last_bit = dir_up ? chain_q[NUM_STAGES-1] : chain_q[0];

  genvar i;
  generate
    for (i = 0; i < NUM_STAGES; i++)
    begin : g_stage
      localparam int GRP_154 = i % NUM_GROUPS;
      // bypassed stages keep their 154 group here; byp masks them in 150 mode
      localparam int GRP_150 = (i < RESUME_IDX) ? (i % NUM_GROUPS) :
                               ((i - RESUME_IDX) % NUM_GROUPS);
      localparam bit IS_BYP = (i >= BYP_FIRST) && (i <= BYP_LAST);
      wire byp = mode150 & IS_BYP;
      wire grp_off = mode150 ? blank[GRP_150] : blank[GRP_154];
      wire up_src;
      wire dn_src;
      if (i == 0)
      begin : g_first
        assign up_src = in_bit;
      end
      else if (i == RESUME_IDX)
      begin : g_resume
        assign up_src = mode150 ? chain_q[BYP_FIRST-1] : chain_q[i-1];
      end
      else
      begin : g_up
        assign up_src = chain_q[i-1];
      end
      if (i == NUM_STAGES-1)
      begin : g_top
        assign dn_src = in_bit;
      end
      else if (i == BYP_FIRST-1)
      begin : g_skip
        assign dn_src = mode150 ? chain_q[RESUME_IDX] : chain_q[i+1];
      end
      else
      begin : g_dn
        assign dn_src = chain_q[i+1];
      end
      assign chain_d[i] = (flush | byp) ? 1'b0 :
                          (sh_rise ? (dir_up ? up_src : dn_src) : chain_q[i]);
      // blanks are sampled on the system clock only, never gated by the shift clock
      assign row_d[i] = chain_q[i] & ~byp & ~grp_off;
    end
  endgenerate

  always_ff @(posedge REF_CLK or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      shclk_prev_q         <= 1'b0;
      chain_q              <= '0;
      cascade_q            <= 1'b0;
      ROW_GATE_OUTPUTS     <= '0;
      FORWARD_DATA_PORT_OE <= 1'b0;
      REVERSE_DATA_PORT_OE <= 1'b0;
    end
    else
    begin
      shclk_prev_q         <= shclk;
      chain_q              <= chain_d;
      ROW_GATE_OUTPUTS     <= row_d;
      FORWARD_DATA_PORT_OE <= ~dir_up;
      REVERSE_DATA_PORT_OE <= dir_up;
      if (sh_fall)
      begin
        cascade_q <= last_bit;
      end
    end
  end

  assign FORWARD_DATA_PORT_O = cascade_q;
  assign REVERSE_DATA_PORT_O = cascade_q;

  trgsd_axil u_axil (
    .clk       (REF_CLK),
    .rst_n     (rst_n_q),
    .awaddr    (S_AXI_AWADDR),
    .awvalid   (S_AXI_AWVALID),
    .awready_q (S_AXI_AWREADY),
    .wdata     (S_AXI_WDATA),
    .wstrb     (S_AXI_WSTRB),
    .wvalid    (S_AXI_WVALID),
    .wready_q  (S_AXI_WREADY),
    .bresp_q   (S_AXI_BRESP),
    .bvalid_q  (S_AXI_BVALID),
    .bready    (S_AXI_BREADY),
    .araddr    (S_AXI_ARADDR),
    .arvalid   (S_AXI_ARVALID),
    .arready_q (S_AXI_ARREADY),
    .rdata_q   (S_AXI_RDATA),
    .rresp_q   (S_AXI_RRESP),
    .rvalid_q  (S_AXI_RVALID),
    .rready    (S_AXI_RREADY),
    .status    ({25'h0, shclk, cascade_q, blank, mode150, dir_up}),
    .ctrl_q    (ctrl)
  );
endmodule
`default_nettype wire

// File: dv/trgsd_properties.sv
`timescale 1ns/1ps
`default_nettype none
module trgsd_properties
  import trgsd_pkg::*;
(
  input wire logic                  REF_CLK,
  input wire logic                  ARST_N,
  input wire logic                  SHIFT_DIRECTION,
  input wire logic                  MODE_150,
  input wire logic                  GROUP_ONE_BLANK,
  input wire logic                  GROUP_TWO_BLANK,
  input wire logic                  REVERSE_DATA_PORT_OE,
  input wire logic [NUM_STAGES-1:0] ROW_GATE_OUTPUTS,
  input wire logic                  S_AXI_AWVALID,
  input wire logic                  S_AXI_AWREADY,
  input wire logic                  S_AXI_WVALID,
  input wire logic                  S_AXI_WREADY,
  input wire logic                  S_AXI_BVALID,
  input wire logic                  S_AXI_BREADY,
  input wire logic [1:0]            S_AXI_BRESP,
  input wire logic                  S_AXI_ARVALID,
  input wire logic                  S_AXI_ARREADY,
  input wire logic                  S_AXI_RVALID
);
  // pins pass synchronisers, so each level is given 16 cycles to settle
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!ARST_N);
  chk_dir_roles: assert property (SHIFT_DIRECTION [*8] ##1 SHIFT_DIRECTION [*8] |-> REVERSE_DATA_PORT_OE)
    else $error("reverse pin not driven in up direction");
  chk_dir_swap: assert property ((!SHIFT_DIRECTION) [*8] ##1 (!SHIFT_DIRECTION) [*8] |-> !REVERSE_DATA_PORT_OE)
    else $error("reverse pin driven in down direction");
  chk_bypass_off: assert property (MODE_150 [*8] ##1 MODE_150 [*8] |-> ROW_GATE_OUTPUTS[78:75] == 4'h0)
    else $error("bypassed outputs not off");
  chk_blank_one: assert property (GROUP_ONE_BLANK [*8] ##1 GROUP_ONE_BLANK [*8]
    |-> !(ROW_GATE_OUTPUTS[0] | ROW_GATE_OUTPUTS[3] | ROW_GATE_OUTPUTS[72]))
    else $error("group one output on while blanked");
  chk_blank_two: assert property (GROUP_TWO_BLANK [*8] ##1 GROUP_TWO_BLANK [*8]
    |-> !(ROW_GATE_OUTPUTS[1] | ROW_GATE_OUTPUTS[4] | ROW_GATE_OUTPUTS[73]))
    else $error("group two output on while blanked");
  chk_write_answer: assert property (S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY
    |-> ##[1:2] S_AXI_BVALID)
    else $error("write response late");
  chk_bresp_hold: assert property (S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID && $stable(S_AXI_BRESP))
    else $error("write response dropped");
  chk_read_answer: assert property (S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID && !S_AXI_ARREADY)
    else $error("read response late");
  chk_resume_group: assert property ((MODE_150 && GROUP_ONE_BLANK) [*8] ##1 (MODE_150 && GROUP_ONE_BLANK) [*8]
    |-> !ROW_GATE_OUTPUTS[79])
    else $error("output 80 not in group one in 150 mode");
  chk_full_group: assert property ((!MODE_150 && GROUP_TWO_BLANK) [*8] ##1 (!MODE_150 && GROUP_TWO_BLANK) [*8]
    |-> !ROW_GATE_OUTPUTS[79])
    else $error("output 80 not in group two in 154 mode");
endmodule
bind trgsd_top trgsd_properties chk_u (
  .REF_CLK, .ARST_N, .SHIFT_DIRECTION, .MODE_150, .GROUP_ONE_BLANK, .GROUP_TWO_BLANK,
  .REVERSE_DATA_PORT_OE, .ROW_GATE_OUTPUTS, .S_AXI_AWVALID, .S_AXI_AWREADY, .S_AXI_WVALID,
  .S_AXI_WREADY, .S_AXI_BVALID, .S_AXI_BREADY, .S_AXI_BRESP, .S_AXI_ARVALID, .S_AXI_ARREADY,
  .S_AXI_RVALID);
`default_nettype wire

// File: dv/trgsd_tcon_model.sv
`timescale 1ns/1ps
`default_nettype none
module trgsd_tcon_model #(
  parameter int HALF = 8
)(
  input  wire logic clk,
  input  wire logic fwd_o,
  input  wire logic fwd_oe,
  input  wire logic rev_o,
  input  wire logic rev_oe,
  output var logic  vsc_q,
  output var logic  dir_q,
  output logic      fwd_pin,
  output logic      rev_pin
);
  logic data_q = 1'b0;
  logic tgl_q = 1'b0;
  initial
  begin
    vsc_q = 1'b0;
    dir_q = 1'b1;
  end
  always @(posedge clk) tgl_q <= !tgl_q;
  // an undriven pin toggles so that a stale level cannot pass for data
  assign fwd_pin = fwd_oe ? fwd_o : (dir_q ? data_q : tgl_q);
  assign rev_pin = rev_oe ? rev_o : (dir_q ? tgl_q : data_q);
  // direction moves only between frames, with the shift clock idle
  task automatic set_dir(input logic d);
    @(posedge clk);
    dir_q <= d;
    repeat (4 * HALF) @(posedge clk);
  endtask
  // data set up a half period before the rise and held past the fall
  task automatic shift_bit(input logic b);
    @(posedge clk);
    data_q <= b;
    repeat (HALF) @(posedge clk);
    vsc_q <= 1'b1;
    repeat (HALF) @(posedge clk);
    vsc_q <= 1'b0;
    repeat (HALF) @(posedge clk);
  endtask
endmodule
`default_nettype wire

// File: dv/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench import trgsd_pkg::*;;
  logic                  clk, arst_n, mode, b1, b2, b3, vsc, dir, fpin, rpin, fo, foe, ro, roe;
  logic                  awv, wv, bre, arv, rre, awr, wr, bv, arr, rv;
  logic [ADDR_W-1:0]     awa, ara;
  logic [31:0]           wd, rdat, d;
  logic [3:0]            ws;
  logic [1:0]            br, rr, r;
  logic [NUM_STAGES-1:0] g, e;
  int                    mismatches = 0, compares = 0, cyc = 0, nact;
  trgsd_tcon_model #(.HALF(8)) tcon_u (.clk(clk), .fwd_o(fo), .fwd_oe(foe), .rev_o(ro), .rev_oe(roe),
    .vsc_q(vsc), .dir_q(dir), .fwd_pin(fpin), .rev_pin(rpin));
  trgsd_top dut_u (
    .REF_CLK(clk), .ARST_N(arst_n), .VERTICAL_SHIFT_CLOCK(vsc), .SHIFT_DIRECTION(dir), .MODE_150(mode),
    .GROUP_ONE_BLANK(b1), .GROUP_TWO_BLANK(b2), .GROUP_THREE_BLANK(b3),
    .FORWARD_DATA_PORT_I(fpin), .FORWARD_DATA_PORT_O(fo), .FORWARD_DATA_PORT_OE(foe),
    .REVERSE_DATA_PORT_I(rpin), .REVERSE_DATA_PORT_O(ro), .REVERSE_DATA_PORT_OE(roe), .ROW_GATE_OUTPUTS(g),
    .S_AXI_AWADDR(awa), .S_AXI_AWVALID(awv), .S_AXI_AWREADY(awr), .S_AXI_WDATA(wd), .S_AXI_WSTRB(ws),
    .S_AXI_WVALID(wv), .S_AXI_WREADY(wr), .S_AXI_BRESP(br), .S_AXI_BVALID(bv), .S_AXI_BREADY(bre),
    .S_AXI_ARADDR(ara), .S_AXI_ARVALID(arv), .S_AXI_ARREADY(arr), .S_AXI_RDATA(rdat), .S_AXI_RRESP(rr),
    .S_AXI_RVALID(rv), .S_AXI_RREADY(rre));
  function automatic int pos(input int n, input logic m, input logic up);
    int p;
    p = (m && n >= BYP_FIRST) ? n + 4 : n;
    return up ? p : NUM_STAGES - 1 - p;
  endfunction
  function automatic int grp(input int i, input logic m);
    return (m && i >= RESUME_IDX) ? (i - RESUME_IDX) % 3 : i % 3;
  endfunction
  task automatic check(input string nm, input logic [NUM_STAGES-1:0] s, x);
    compares++;
    if (s !== x)
    begin
      mismatches++;
      $display("wrong value %s expected %0h seen %0h", nm, x, s);
    end
  endtask
  task automatic test_done();
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] v, input logic [3:0] s);
    @(posedge clk);
    awa <= a;
    wd <= v;
    ws <= s;
    awv <= 1'b1;
    wv <= 1'b1;
    bre <= 1'b1;
    fork
      begin
        do @(posedge clk); while (!awr);
        awv <= 1'b0;
      end
      begin
        do @(posedge clk); while (!wr);
        wv <= 1'b0;
      end
    join
    do @(posedge clk); while (!bv);
    r = br;
    bre <= 1'b0;
  endtask
  task automatic rd_reg(input logic [7:0] a);
    @(posedge clk);
    ara <= a;
    arv <= 1'b1;
    rre <= 1'b1;
    do @(posedge clk); while (!arr);
    arv <= 1'b0;
    do @(posedge clk); while (!rv);
    d = rdat;
    r = rr;
    rre <= 1'b0;
  endtask
  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // ceiling well above the roughly 31500 cycles the tests need
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 80000)
    begin
      mismatches++;
      test_done();
    end
  end
  initial
  begin
    {arst_n, mode, b1, b2, b3, awv, wv, bre, arv, rre} = '0;
    {awa, ara, wd, ws} = '0;
    repeat (3) @(posedge clk);
    arst_n <= 1'b1;
    repeat (10) @(posedge clk);
    rd_reg(REG_CTRL);
    check("ctrl reset", d, CTRL_RESET);
    rd_reg(REG_STATUS);
    check("status", d[6:0], 7'h01);
    wr_reg(REG_STATUS, 32'h1, 4'hf);
    check("status write resp", r, RESP_SLVERR);
    rd_reg(8'h08);
    check("unmapped data", d, 32'h0);
    check("unmapped resp", r, RESP_SLVERR);
    wr_reg(REG_CTRL, 32'h1, 4'h0);
    rd_reg(REG_CTRL);
    check("ctrl lane off", d[0], 1'b0);
    $display("register test done");
    for (int c = 0; c < 4; c++)
    begin
      mode <= c[1];
      tcon_u.set_dir(!c[0]);
      nact = c[1] ? 150 : 154;
      check("reverse oe", roe, dir);
      check("forward oe", foe, !dir);
      tcon_u.shift_bit(1'b1);
      for (int n = 0; n <= nact; n++)
      begin
        e = '0;
        if (n < nact)
          e[pos(n, c[1], dir)] = 1'b1;
        check("row walk", g, e);
        check("cascade out", dir ? rpin : fpin, n == nact - 1);
        tcon_u.shift_bit(1'b0);
      end
      for (int n = 0; n < nact; n++)
        tcon_u.shift_bit(1'b1);
      // blanks move with the shift clock idle
      for (int k = 0; k < 8; k++)
      begin
        {b3, b2, b1} <= k[2:0];
        repeat (20) @(posedge clk);
        for (int i = 0; i < NUM_STAGES; i++)
          e[i] = !(c[1] && i >= BYP_FIRST && i <= BYP_LAST) && !k[grp(i, c[1])];
        check("blanked rows", g, e);
      end
      {b3, b2, b1} <= 3'h0;
      wr_reg(REG_CTRL, 32'h1, 4'h1);
      check("ctrl write resp", r, RESP_OKAY);
      rd_reg(REG_CTRL);
      check("flush bit", d[0], 1'b1);
      check("flushed rows", g, '0);
      wr_reg(REG_CTRL, 32'h0, 4'h1);
      $display("shift test %0d done", c);
    end
    test_done();
  end
endmodule
`default_nettype wire
